/* File: common/spc_params.svh */
/*
 * Constants of the slow-poll / wake-debounce configuration bank.
 * Assumes a 10 MHz system clock and 32-bit command frames.
 */
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH

// register addresses, bits 31..25 of the command word
`define SPC_ADDR_SLOW_BAT 7'h18
`define SPC_ADDR_SLOW_GND 7'h19
`define SPC_ADDR_DEB_BAT 7'h1A
`define SPC_REG_RST 24'h000000
// channel counts of the two banks
`define SPC_N_BAT 8
`define SPC_N_GND 14
// answer word layout
`define SPC_FAULT_BIT 23
`define SPC_INTF_BIT 22
`define SPC_FRAME_BITS 32
`define SPC_CNT_LAST 5'h1F
// slow channels are polled on one base tick out of this many
`define SPC_SLOW_DIV 4
// timing
`define SPC_CLK_MHZ 10.0
`define SPC_DEB_TIME_MS 1.2
`define SPC_POLL_TIME_US 20.0

`endif

/* File: common/spc_pkg.sv */
/*
 * Types shared by the configuration bank and its serial front end.
 * Assumes spc_params.svh on the include path.
 */
`include "spc_params.svh"

package spc_pkg;

   // one command frame as it arrives, msb first
   typedef struct packed {
      logic [6:0] addr;
      logic wr;
      logic [23:0] data;
   } spc_cmd_s;

   // shared polling sequencer
   typedef enum logic [2:0] {
      SPC_IDLE = 3'b001,
      SPC_BASE = 3'b010,
      SPC_EXTRA = 3'b100
   } spc_state_e;

endpackage

/* File: hdl/spc_link_shift.sv */
/*
 * Serial front end on the link clock: shifts in 32-bit command words
 * and shifts out the answer word prepared by the system domain.
 * Assumes sclk idles low, the device samples mosi on the rising edge,
 * the master samples miso on the falling edge, and chip select stays
 * high for at least 1 us between frames.
 */
`timescale 1ns/10ps
`include "spc_params.svh"

module spc_link_shift (
   input wire logic spi_sclk_i,
   input wire logic sys_rst_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_mosi_i,
   input wire logic [31:0] resp_i,
   output logic spi_miso_o,
   output logic spi_miso_oe_n_o,
   output spc_pkg::spc_cmd_s cmd_o,
   output logic done_tog_o
);

   logic frame_rst;
   logic [4:0] cnt_q, cnt_d;
   logic [31:0] rx_q, rx_d;
   logic [31:0] tx_q, tx_d;
   spc_pkg::spc_cmd_s cmd_q, cmd_d;
   logic tog_q, tog_d;

   // chip select high ends any partial frame; the clock stops between frames
   assign frame_rst = sys_rst_i | spi_cs_n_i;

   // next values: count bits, shift in, capture a whole word and flag it
   always_comb begin
      cnt_d = cnt_q + 5'h01;
      rx_d = {rx_q[30:0], spi_mosi_i};
      tx_d = (cnt_q == 5'h00) ? resp_i : tx_q;
      cmd_d = cmd_q;
      tog_d = tog_q;
      if (cnt_q == `SPC_CNT_LAST) begin
         cmd_d = rx_d; // [R06]
         tog_d = ~tog_q;
      end
   end

   always_ff @(posedge spi_sclk_i or posedge frame_rst) begin
      if (frame_rst) begin
         cnt_q <= 5'h00;
         rx_q <= 32'h00000000;
         tx_q <= 32'h00000000;
      end else begin
         cnt_q <= cnt_d;
         rx_q <= rx_d;
         tx_q <= tx_d;
      end
   end

   // word and toggle survive chip select so the system side can read them
   always_ff @(posedge spi_sclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cmd_q <= '0;
         tog_q <= 1'b0;
      end else begin
         cmd_q <= cmd_d;
         tog_q <= tog_d;
      end
   end

   // first bit comes straight from the answer word, the rest from the copy
   assign spi_miso_o = (cnt_q == 5'h00) ? resp_i[31] : tx_q[5'h1F - cnt_q]; // [R07]
   assign spi_miso_oe_n_o = spi_cs_n_i;
   assign cmd_o = cmd_q;
   assign done_tog_o = tog_q;

endmodule // spc_link_shift

/* File: hdl/spc_top.sv */
/*
 * Per-channel slow-poll and battery-side wake-debounce configuration with the shared
 * low-power polling sequencer it steers, plus the register access path.
 * Assumes base_tick_i is a one-cycle pulse at the base polling rate from
 * the low-power configuration logic, and that the comparator inputs
 * come from the analog front end without a clock relation.
 */
`timescale 1ns/10ps
`include "spc_params.svh"

// What this block does
// R01: clear slow bit: channel polled on every base tick that finds the sequencer idle in low-power polling.
// R02: set slow bit: channel polled on one base tick in four.
// R03: base polling rate comes from outside this bank, via base tick.
// R04: clear debounce bit: decide change by voltage-difference result at poll end.
// R05: set debounce bit: current stays on 1.2 ms more, then level decides.
// R06: command word: address bits 31..25, write bit 24; addresses 0x18, 0x19, 0x1A.
// R07: answer word: fault bit 23, interrupt flag bit 22, register data 21..0.
// R08: ground-side slow register: channels 0..13 in bits 0..13, rest zero.
// R09: battery-side registers: channels 0..7 in bits 0..7, rest zero.
// R10: reset clears all three registers.
// R11: settings act only during low-power polling; otherwise stored, no effect.
module spc_top #(
   parameter int N_BAT = `SPC_N_BAT,
   parameter int N_GND = `SPC_N_GND,
   parameter int POLL_CYC = int'($ceil(`SPC_POLL_TIME_US * `SPC_CLK_MHZ)),
   parameter int DEB_CYC = int'($ceil(`SPC_DEB_TIME_MS * 1000.0 * `SPC_CLK_MHZ))
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic spi_sclk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_mosi_i,
   output logic spi_miso_o,
   output logic spi_miso_oe_n_o,
   input wire logic fault_status_i,
   input wire logic int_flag_i,
   input wire logic low_power_active_i,
   input wire logic base_tick_i,
   input wire logic [N_BAT+N_GND-1:0] delta_cmp_i,
   input wire logic [N_BAT+N_GND-1:0] level_cmp_i,
   output logic [N_BAT+N_GND-1:0] poll_on_o,
   output logic [N_BAT+N_GND-1:0] sample_o,
   output logic [N_BAT+N_GND-1:0] switch_closed_o
);

   localparam int NCH = N_BAT + N_GND;
   localparam logic [15:0] POLL_LAST = 16'(POLL_CYC - 1);
   localparam logic [15:0] DEB_LAST = 16'(DEB_CYC - 1);

   // one-hot register select, used for write and for readback
   function automatic logic [2:0] reg_sel(input logic [6:0] a);
      reg_sel = {a == `SPC_ADDR_DEB_BAT, a == `SPC_ADDR_SLOW_GND, a == `SPC_ADDR_SLOW_BAT};
   endfunction

   spc_pkg::spc_cmd_s cmd;
   logic done_tog;
   logic [31:0] resp_q, resp_d;
   logic tog_m_q, tog_s_q, tog_p_q;
   logic done;
   logic [2:0] sel;
   logic [N_BAT-1:0] slow_bat_q, slow_bat_d, deb_bat_q, deb_bat_d;
   logic [N_GND-1:0] slow_gnd_q, slow_gnd_d;
   logic [21:0] rd_data;
   logic [NCH-1:0] dlt_m_q, dlt_s_q, lvl_m_q, lvl_s_q;
   spc_pkg::spc_state_e st_q, st_d;
   logic [15:0] tmr_q, tmr_d;
   logic [1:0] qcnt_q, qcnt_d;
   logic [NCH-1:0] sched_q, sched_d, dsched_q, dsched_d;
   logic [NCH-1:0] pon_q, pon_d, smp_q, smp_d, sw_q, sw_d;
   logic [NCH-1:0] slow_vec, deb_vec;

   spc_link_shift u_link (
      .spi_sclk_i(spi_sclk_i),
      .sys_rst_i(sys_rst_i),
      .spi_cs_n_i(spi_cs_n_i),
      .spi_mosi_i(spi_mosi_i),
      .resp_i(resp_q),
      .spi_miso_o(spi_miso_o),
      .spi_miso_oe_n_o(spi_miso_oe_n_o),
      .cmd_o(cmd),
      .done_tog_o(done_tog)
   );

   // frame toggle crosses by two flops; the word is stable long before it
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tog_m_q <= 1'b0;
         tog_s_q <= 1'b0;
         tog_p_q <= 1'b0;
         dlt_m_q <= '0;
         dlt_s_q <= '0;
         lvl_m_q <= '0;
         lvl_s_q <= '0;
      end else begin
         tog_m_q <= done_tog;
         tog_s_q <= tog_m_q;
         tog_p_q <= tog_s_q;
         dlt_m_q <= delta_cmp_i;
         dlt_s_q <= dlt_m_q;
         lvl_m_q <= level_cmp_i;
         lvl_s_q <= lvl_m_q;
      end
   end

   assign done = tog_s_q ^ tog_p_q;
   assign sel = reg_sel(cmd.addr); // [R06]

   // register writes keep only the channel bits, so unused bits stay zero
   always_comb begin
      slow_bat_d = slow_bat_q;
      slow_gnd_d = slow_gnd_q;
      deb_bat_d = deb_bat_q;
      if (done && cmd.wr) begin
         if (sel[0]) slow_bat_d = cmd.data[N_BAT-1:0]; // [R06] [R09]
         if (sel[1]) slow_gnd_d = cmd.data[N_GND-1:0]; // [R06] [R08]
         if (sel[2]) deb_bat_d = cmd.data[N_BAT-1:0]; // [R06] [R09]
      end
   end

   // answer shows the addressed register after any write of the same frame
   always_comb begin
      rd_data = 22'h000000;
      if (sel[0]) rd_data = 22'(slow_bat_d); // [R09]
      if (sel[1]) rd_data = 22'(slow_gnd_d); // [R08]
      if (sel[2]) rd_data = 22'(deb_bat_d); // [R09]
      resp_d = resp_q;
      if (done) begin
         resp_d = 32'h00000000;
         resp_d[`SPC_FAULT_BIT] = fault_status_i; // [R07]
         resp_d[`SPC_INTF_BIT] = int_flag_i; // [R07]
         resp_d[21:0] = rd_data; // [R07]
      end
   end

   // power-on reset clears the whole bank
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         slow_bat_q <= N_BAT'(`SPC_REG_RST); // [R10]
         slow_gnd_q <= N_GND'(`SPC_REG_RST); // [R10]
         deb_bat_q <= N_BAT'(`SPC_REG_RST); // [R10]
         resp_q <= 32'h00000000;
      end else begin
         slow_bat_q <= slow_bat_d;
         slow_gnd_q <= slow_gnd_d;
         deb_bat_q <= deb_bat_d;
         resp_q <= resp_d;
      end
   end

   // ground-side channels have no debounce bit in this bank
   assign slow_vec = {slow_gnd_q, slow_bat_q};
   assign deb_vec = {{N_GND{1'b0}}, deb_bat_q};

   // one sequencer for all channels; a tick that lands mid-poll is dropped
   // but still advances the divide-by-four phase, so slow rates stay exact
   always_comb begin
      st_d = st_q;
      tmr_d = tmr_q + 16'h0001;
      sched_d = sched_q;
      dsched_d = dsched_q;
      smp_d = '0;
      qcnt_d = qcnt_q;
      if (base_tick_i) qcnt_d = qcnt_q + 2'h1; // [R03]
      case (st_q)
         spc_pkg::SPC_IDLE: begin
            tmr_d = 16'h0000;
            if (base_tick_i) begin
               sched_d = ~slow_vec | {NCH{qcnt_q == 2'h0}}; // [R01] [R02]
               dsched_d = sched_d & deb_vec;
               if (|sched_d) st_d = spc_pkg::SPC_BASE;
            end
         end
         spc_pkg::SPC_BASE: begin
            if (tmr_q == POLL_LAST) begin
               smp_d = sched_q & ~dsched_q; // [R04]
               tmr_d = 16'h0000;
               st_d = (|dsched_q) ? spc_pkg::SPC_EXTRA : spc_pkg::SPC_IDLE; // [R05]
            end
         end
         spc_pkg::SPC_EXTRA: begin
            if (tmr_q == DEB_LAST) begin
               smp_d = dsched_q; // [R05]
               st_d = spc_pkg::SPC_IDLE;
            end
         end
         default: st_d = spc_pkg::SPC_IDLE;
      endcase
      if (st_d == spc_pkg::SPC_IDLE) begin
         sched_d = '0;
         dsched_d = '0;
      end
      if (!low_power_active_i) begin // [R11]
         st_d = spc_pkg::SPC_IDLE;
         tmr_d = 16'h0000;
         qcnt_d = 2'h0;
         sched_d = '0;
         dsched_d = '0;
         smp_d = '0;
      end
      pon_d = '0;
      if (st_d == spc_pkg::SPC_BASE) pon_d = sched_d;
      if (st_d == spc_pkg::SPC_EXTRA) pon_d = dsched_d; // [R05]
   end

   // per channel: debounced channels take the level, others the difference
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_ch
         always_comb begin
            sw_d[gi] = sw_q[gi];
            if (smp_d[gi] && dsched_q[gi]) sw_d[gi] = lvl_s_q[gi]; // [R05]
            if (smp_d[gi] && !dsched_q[gi]) sw_d[gi] = sw_q[gi] ^ dlt_s_q[gi]; // [R04]
         end
      end
   endgenerate

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_q <= spc_pkg::SPC_IDLE;
         tmr_q <= 16'h0000;
         qcnt_q <= 2'h0;
         sched_q <= '0;
         dsched_q <= '0;
         pon_q <= '0;
         smp_q <= '0;
         sw_q <= '0;
      end else begin
         st_q <= st_d;
         tmr_q <= tmr_d;
         qcnt_q <= qcnt_d;
         sched_q <= sched_d;
         dsched_q <= dsched_d;
         pon_q <= pon_d;
         smp_q <= smp_d;
         sw_q <= sw_d;
      end
   end

   assign poll_on_o = pon_q;
   assign sample_o = smp_q;
   assign switch_closed_o = sw_q;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   // register access checks
   wr_slow_bat_a: assert property ( // [R06]
      done && cmd.wr && cmd.addr == `SPC_ADDR_SLOW_BAT |=>
         slow_bat_q == $past(cmd.data[N_BAT-1:0]) && resp_q[21:N_BAT] == 0)
      else $error("battery slow register write not stored");
   wr_deb_bat_a: assert property ( // [R09]
      done && cmd.wr && cmd.addr == `SPC_ADDR_DEB_BAT |=>
         deb_bat_q == $past(cmd.data[N_BAT-1:0]) && resp_q[21:0] == 22'(deb_bat_q))
      else $error("battery debounce register write not stored");
   rd_gnd_bits_a: assert property ( // [R08]
      done && cmd.addr == `SPC_ADDR_SLOW_GND |=>
         resp_q[21:N_GND] == 0 && resp_q[N_GND-1:0] == slow_gnd_q)
      else $error("ground slow readback wrong");
   resp_flags_a: assert property ( // [R07]
      done |=> resp_q[`SPC_FAULT_BIT] == $past(fault_status_i)
         && resp_q[`SPC_INTF_BIT] == $past(int_flag_i) && resp_q[31:24] == 0)
      else $error("answer flags wrong");
   write_hold_a: assert property ( // [R10]
      !done |=> $stable(slow_bat_q) && $stable(slow_gnd_q) && $stable(deb_bat_q))
      else $error("register changed without a frame");

   // sequencer checks
   normal_quiet_a: assert property ( // [R11]
      !low_power_active_i |=> poll_on_o == 0 && sample_o == 0)
      else $error("polling outside low-power mode");
   fast_start_a: assert property ( // [R01]
      low_power_active_i && base_tick_i && st_q == spc_pkg::SPC_IDLE && !slow_vec[0]
         ##1 low_power_active_i |-> poll_on_o[0])
      else $error("fast channel not polled on tick");
   slow_skip_a: assert property ( // [R02]
      base_tick_i && st_q == spc_pkg::SPC_IDLE && slow_vec[0] && qcnt_q != 2'h0
         |=> !poll_on_o[0])
      else $error("slow channel polled off its quarter");
   base_end_a: assert property ( // [R04]
      low_power_active_i && st_q == spc_pkg::SPC_BASE && tmr_q == POLL_LAST
         |=> sample_o == $past(sched_q & ~dsched_q))
      else $error("base window end sample wrong");
   extra_hold_a: assert property ( // [R05]
      low_power_active_i && st_q == spc_pkg::SPC_EXTRA && tmr_q != DEB_LAST
         ##1 low_power_active_i |-> sample_o == 0 && poll_on_o == $past(dsched_q))
      else $error("debounce current dropped early");
   // phase and decision checks; a dropped tick must still move the quarter phase
   quarter_step_a: assert property ( // [R03]
      low_power_active_i |=> qcnt_q == 2'($past(qcnt_q) + $past(base_tick_i)))
      else $error("quarter counter out of step");
   deb_end_a: assert property ( // [R05]
      low_power_active_i && st_q == spc_pkg::SPC_EXTRA && tmr_q == DEB_LAST
         |=> sample_o == $past(dsched_q) && poll_on_o == 0)
      else $error("debounce window end sample wrong");
   switch_hold_a: assert property ( // [R04]
      sample_o == 0 |-> $stable(switch_closed_o))
      else $error("switch state changed without a decision");

   cov_write_c: cover property (done && cmd.wr);
   cov_read_c: cover property (done && !cmd.wr && sel != 3'b000);
   cov_fast_c: cover property (sample_o != 0 && poll_on_o == 0);
   cov_deb_c: cover property (st_q == spc_pkg::SPC_EXTRA && tmr_q == DEB_LAST);
   cov_slow_c: cover property (base_tick_i && st_q == spc_pkg::SPC_IDLE && qcnt_q == 2'h1);

endmodule // spc_top

/* File: tb/spc_master.sv */
/* Link master model for the slow-poll bank: sends one 32-bit command word per frame.
   Assumes the device shifts out after sclk rising edges and answers one frame late. */
`timescale 1ns/10ps

module spc_master (
   output logic sclk_o,
   output logic cs_n_o,
   output logic mosi_o,
   input wire logic miso_i
);
   logic [31:0] rx_q;
   event done_ev;
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   // one frame, msb first; sclk runs only while selected, data sampled on falling edges
   task automatic xfer(input logic [31:0] tx);
      #37;
      cs_n_o = 1'b0;
      mosi_o = tx[31];
      #62.5;
      rx_q[31] = miso_i;
      for (int k = 1; k <= 32; k++) begin
         sclk_o = 1'b1;
         #62.5;
         sclk_o = 1'b0;
         if (k < 32) begin
            rx_q[31-k] = miso_i;
            mosi_o = tx[31-k];
         end
         #62.5;
      end
      cs_n_o = 1'b1;
      mosi_o = ~mosi_o; // released line must not keep a stale bit
      -> done_ev;
      #1500; // gap above 1 us so the answer word is ready
   endtask
endmodule // spc_master

/* File: tb/tb_top.sv */
/* Self-checking bench for the slow-poll / wake-debounce bank.
   Assumes spc_pkg, spc_params.svh and the link master model are compiled first. */
`timescale 1ns/10ps
`include "spc_params.svh"

module tb_top;
   localparam int NCH = `SPC_N_BAT + `SPC_N_GND;
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic fault_q = 1'b0, intf_q = 1'b0, lp_q = 1'b0, tick_q = 1'b0, prev_on = 1'b0;
   logic [NCH-1:0] delta_q = '0, level_q = '0, sw_m, poll_on, sample, sw_closed;
   logic sclk, cs_n, mosi, miso, miso_out, miso_oe_n, miso_hold = 1'b0;
   logic [23:0] regs [3];
   logic [31:0] exp_ans [$];
   logic [NCH-1:0] exp_poll [$], exp_samp [$], exp_sw [$];
   int fail_count = 0, total_checks = 0, qcnt = 0;

   initial forever #50 sys_clk_i = ~sys_clk_i;
   // a released data-out wire shows the inverse of its last bit
   assign miso = miso_oe_n ? ~miso_hold : miso_out;
   always @(posedge miso_oe_n) miso_hold = miso_out;

   spc_master m (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
   spc_top #(.POLL_CYC(4), .DEB_CYC(8)) dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso_out),
      .spi_miso_oe_n_o(miso_oe_n), .fault_status_i(fault_q), .int_flag_i(intf_q),
      .low_power_active_i(lp_q), .base_tick_i(tick_q), .delta_cmp_i(delta_q),
      .level_cmp_i(level_q), .poll_on_o(poll_on), .sample_o(sample),
      .switch_closed_o(sw_closed));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // one frame; the answer it earns is seen during the next frame
   task automatic bus(input logic [6:0] addr, input logic wr, input logic [23:0] data);
      logic [31:0] e;
      logic f, n;
      f = 1'($urandom);
      n = 1'($urandom);
      @(posedge sys_clk_i);
      fault_q <= f;
      intf_q <= n;
      e = {8'h00, f, n, 22'h0};
      if (addr >= `SPC_ADDR_SLOW_BAT && addr <= `SPC_ADDR_DEB_BAT) begin
         if (wr) begin
            regs[addr-`SPC_ADDR_SLOW_BAT] = data & ((addr == `SPC_ADDR_SLOW_GND) ?
               24'h003FFF : 24'h0000FF);
         end
         e[21:0] = regs[addr-`SPC_ADDR_SLOW_BAT][21:0];
      end
      exp_ans.push_back(e);
      m.xfer({addr, wr, data});
   endtask

   task automatic lp(input logic on);
      @(posedge sys_clk_i);
      lp_q <= on;
      qcnt = 0;
   endtask

   // one base tick with fresh comparator levels held through the whole poll
   task automatic tick;
      logic [NCH-1:0] slow, deb, sch, nd;
      slow = {regs[1][13:0], regs[0][7:0]};
      @(posedge sys_clk_i);
      delta_q <= NCH'($urandom);
      level_q <= NCH'($urandom);
      repeat (4) @(posedge sys_clk_i);
      tick_q <= 1'b1;
      @(posedge sys_clk_i);
      tick_q <= 1'b0;
      if (lp_q) begin
         sch = ~slow | ((qcnt == 0) ? slow : '0);
         qcnt = (qcnt + 1) % `SPC_SLOW_DIV;
         deb = {14'h0, regs[2][7:0]} & sch;
         nd = sch & ~deb;
         if (sch != '0) exp_poll.push_back(sch);
         sw_m ^= delta_q & nd;
         if (nd != '0) begin
            exp_samp.push_back(nd);
            exp_sw.push_back(sw_m);
         end
         sw_m = (sw_m & ~deb) | (level_q & deb);
         if (deb != '0) begin
            exp_samp.push_back(deb);
            exp_sw.push_back(sw_m);
         end
      end
      repeat (18) @(posedge sys_clk_i);
   endtask

   task automatic read_all;
      for (int a = 0; a < 3; a++) bus(7'(`SPC_ADDR_SLOW_BAT + a), 1'b0, 24'($urandom));
   endtask

   // answers are matched with the oldest note as each frame ends
   initial begin
      forever begin
         @(m.done_ev);
         chk(m.rx_q, exp_ans.pop_front());
      end
   end

   // poll starts and decisions are matched at the falling edge, when settled
   always @(negedge sys_clk_i) begin
      if (poll_on != '0 && !prev_on) chk(32'(poll_on), 32'(exp_poll.pop_front()));
      if (sample != '0) begin
         chk(32'(sample), 32'(exp_samp.pop_front()));
         chk(32'(sw_closed), 32'(exp_sw.pop_front()));
      end
      chk(32'(miso_oe_n), 32'(cs_n));
      prev_on = (poll_on != '0);
   end

   initial begin
      #1000000;
      fail_count++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      wrap_up();
   end

   initial begin
      void'($urandom(32'h2135));
      for (int r = 0; r < 2; r++) begin
         regs = '{default: 24'h0};
         sw_m = '0;
         exp_ans.delete();
         exp_ans.push_back(32'h0);
         @(posedge sys_clk_i);
         sys_rst_i <= 1'b1;
         repeat (8) @(posedge sys_clk_i);
         sys_rst_i <= 1'b0;
         read_all();
         for (int a = 0; a < 3; a++) bus(7'(`SPC_ADDR_SLOW_BAT + a), 1'b1, 24'hFFFFFF);
         bus(7'h1B, 1'b1, 24'hFFFFFF);
         bus(7'h00, 1'b0, 24'h000000);
         $display("register test %0d done", r);
         for (int a = 0; a < 3; a++) bus(7'(`SPC_ADDR_SLOW_BAT + a), 1'b1, 24'($urandom));
         lp(1'b1);
         repeat (8) tick();
         $display("polling test %0d done", r);
         // settings stay stored but idle outside low-power polling
         lp(1'b0);
         repeat (2) tick();
         chk(32'(poll_on), 32'h0);
         chk(32'(exp_poll.size() + exp_samp.size() + exp_sw.size()), 32'h0);
         read_all();
         $display("normal mode test %0d done", r);
      end
      bus(7'h00, 1'b0, 24'h000000);
      wrap_up();
   end
endmodule // tb_top
